// *** cmpc_map.svh ***
// timing figures, counter width, address base and control reset value of the charger controller
`ifndef CMPC_MAP_SVH
`define CMPC_MAP_SVH
`define CMPC_CLK_MHZ        50
`define CMPC_WAKE_US        500
`define CMPC_INT_PULSE_US   256
`define CMPC_WDT_WAIT_MS    32
`define CMPC_WDT_PERIOD_MS  40
`define CMPC_RECOV_SHORT_MS 21
`define CMPC_RECOV_LONG_MS  100
`define CMPC_HICCUP_SHORT_MS 10
`define CMPC_HICCUP_LONG_MS 50
`define CMPC_CNT_W          24
`define CMPC_ADDR_BASE      7'h50
// control bits after reset: auto-recovery on, everything else off
`define CMPC_CFG_RESET      10'h010
`endif

// *** cmpc_pkg.sv ***
// types shared by the charger mode and protection controller
package cmpc_pkg;
  // operating modes, one-hot
  typedef enum logic [5:0] {
    CMPC_LOWPWR  = 6'h01,
    CMPC_STANDBY = 6'h02,
    CMPC_BYPASS  = 6'h04,
    CMPC_RBYPASS = 6'h08,
    CMPC_HALVE   = 6'h10,
    CMPC_RHALVE  = 6'h20
  } cmpc_mode_e;
  // soft-start sequencer states, one-hot
  typedef enum logic [3:0] {
    CMPC_SS_IDLE  = 4'h1,
    CMPC_SS_CHECK = 4'h2,
    CMPC_SS_RUN   = 4'h4,
    CMPC_SS_HOLD  = 4'h8
  } cmpc_ss_e;
  // host-written control bits
  typedef struct packed {
    logic       chargeEnable;
    logic       reverseEnable;
    logic       topologySelect;
    logic [1:0] inputSwitchControl;
    logic       autoRecoveryEnable;
    logic       recoveryDeglitchSelect;
    logic       wirelessGoodLowpowerEn;
    logic       wirelessGoodIndicatorEn;
    logic       outErrOffTimeSel;
  } cmpc_cfg_s;
  // analog comparator levels, all asynchronous
  typedef struct packed {
    logic inputOvervoltage;
    logic outputOvervoltage;
    logic inputOvercurrent;
    logic wirelessReverseOvercurrent;
    logic outputShortError;
    logic dieOvertemperature;
    logic flyingCapDiagnostic;
    logic converterOvercurrent;
    logic lowInputStatus;
  } cmpc_fault_s;
endpackage

// *** cmpc_ctrl.sv ***
// mode decode, watchdog, power-up and protection reactions of the charger
`timescale 1ns/1ns
`include "cmpc_map.svh"
module cmpc_ctrl #(
  parameter int CLK_MHZ    = `CMPC_CLK_MHZ,
  parameter int WAKE_CYC   = `CMPC_WAKE_US * CLK_MHZ,
  parameter int PULSE_CYC  = `CMPC_INT_PULSE_US * CLK_MHZ,
  parameter int WDT_CYC    = `CMPC_WDT_PERIOD_MS * 1000 * CLK_MHZ,
  parameter int WAIT_CYC   = `CMPC_WDT_WAIT_MS * 1000 * CLK_MHZ,
  parameter int RECOV0_CYC = `CMPC_RECOV_SHORT_MS * 1000 * CLK_MHZ,
  parameter int RECOV1_CYC = `CMPC_RECOV_LONG_MS * 1000 * CLK_MHZ,
  parameter int HICC0_CYC  = `CMPC_HICCUP_SHORT_MS * 1000 * CLK_MHZ,
  parameter int HICC1_CYC  = `CMPC_HICCUP_LONG_MS * 1000 * CLK_MHZ
) (
  // clock and supply-lockout reset
  input  wire  logic                 ref_clk,
  input  wire  logic                 nrst,
  // pins
  input  wire  logic                 enPinN,
  input  wire  logic [1:0]           addrLevel,
  input  wire  logic                 inputPresent,
  input  wire  logic                 wirelessInputRaw,
  input  wire  cmpc_pkg::cmpc_fault_s faultRaw,
  // host side, same clock
  input  wire  logic                 cfgWr,
  input  wire  cmpc_pkg::cmpc_cfg_s  cfgWrData,
  input  wire  logic                 regRead,
  input  wire  logic                 wdtFlagClr,
  // status
  output logic                       hostReady_r,
  output logic [6:0]                 slaveAddr_r,
  output cmpc_pkg::cmpc_cfg_s        cfg_r,
  output cmpc_pkg::cmpc_mode_e       mode_r,
  output logic                       switchOn_r,
  output logic                       watchdogTimeoutStatus_r,
  output logic                       watchdogTimeoutFlag_r,
  output logic                       intN_r,
  output logic                       wirelessInputGood_r
);
  import cmpc_pkg::*;
  localparam int CW = `CMPC_CNT_W;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [13:0] pinMeta;     // first stage, read only by pinSync
  logic [13:0] pinSync;     // second stage
  cmpc_fault_s flt;         // synchronised fault levels
  cmpc_fault_s fltPrev;     // for rising-edge events
  logic        enLow;       // enable pin driven low
  logic [1:0]  addrSync;
  logic        vinOk;
  logic        wirelessSync;
  logic        wirelessPrev;
  assign {enLow, addrSync, vinOk, wirelessSync} = {~pinSync[13], pinSync[12:9]};
  assign flt = cmpc_fault_s'(pinSync[8:0] ^ 9'h000);

  // two flops on every asynchronous input
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      // enable pin idles high so reset lands in low power
      pinMeta <= 14'h2000;
      pinSync <= 14'h2000;
    end
    else
    begin
      pinMeta <= {enPinN, addrLevel, inputPresent, wirelessInputRaw, faultRaw};
      pinSync <= pinMeta;
    end

  // ----------------------------------------------------------------
  // power-up: wake delay and address capture
  // ----------------------------------------------------------------
  logic [CW-1:0] wakeCnt_r;

  // address is sampled after the pin settled, then the host is let in
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      wakeCnt_r   <= '0;
      hostReady_r <= 1'b0;
      slaveAddr_r <= `CMPC_ADDR_BASE;
    end
    else if (!hostReady_r)
    begin
      wakeCnt_r <= wakeCnt_r + 1'b1;
      if (wakeCnt_r == CW'(WAKE_CYC - 1))
      begin
        hostReady_r <= 1'b1;
        slaveAddr_r <= `CMPC_ADDR_BASE + {5'h00, addrSync};
      end
    end

  // accesses are only seen once the host interface is released
  logic hostAcc;
  logic hostWr;
  assign hostWr  = cfgWr & hostReady_r;
  assign hostAcc = hostWr | (regRead & hostReady_r);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  cmpc_mode_e modeNxt;
  always_comb
  begin
    if (!enLow)
      modeNxt = CMPC_LOWPWR;
    else if (!cfg_r.chargeEnable)
      modeNxt = CMPC_STANDBY;
    else
      unique case ({cfg_r.topologySelect, cfg_r.reverseEnable})
        2'b00: modeNxt = CMPC_BYPASS;
        2'b01: modeNxt = CMPC_RBYPASS;
        2'b10: modeNxt = CMPC_HALVE;
        2'b11: modeNxt = CMPC_RHALVE;
      endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      mode_r <= CMPC_LOWPWR;
    else
      mode_r <= modeNxt;

  // ----------------------------------------------------------------
  // protection reactions per mode
  // ----------------------------------------------------------------
  logic protOn;        // sensing powered
  logic charging;
  logic isRev;
  logic ovpAny;
  logic clrChg;
  logic clrRev;
  logic clrSw;
  logic stopOcp;       // bypass stop, immediate restart
  logic stopOvp;       // bypass stop, recovery deglitch
  logic stopShort;     // bypass hiccup
  assign protOn   = mode_r != CMPC_LOWPWR;
  assign charging = protOn && mode_r != CMPC_STANDBY;
  assign isRev    = mode_r == CMPC_RBYPASS || mode_r == CMPC_RHALVE;
  assign ovpAny   = flt.inputOvervoltage | flt.outputOvervoltage;

  // fault to action table; one flop-free decode feeds all owners
  always_comb
  begin
    clrChg    = 1'b0;
    clrRev    = 1'b0;
    stopOcp   = 1'b0;
    stopOvp   = 1'b0;
    stopShort = 1'b0;
    clrSw = protOn && cfg_r.inputSwitchControl[1]
            && flt.wirelessReverseOvercurrent;
    unique case (mode_r)
      CMPC_BYPASS:
      begin
        stopOcp   = flt.inputOvercurrent | flt.converterOvercurrent;
        clrChg    = flt.dieOvertemperature
                  | (ovpAny & ~cfg_r.autoRecoveryEnable);
        stopOvp   = ovpAny & cfg_r.autoRecoveryEnable;
        stopShort = flt.outputShortError;
      end
      CMPC_RBYPASS, CMPC_RHALVE:
      begin
        clrRev = flt.inputOvercurrent | flt.dieOvertemperature
               | flt.converterOvercurrent;
        clrChg = clrRev | ovpAny
               | (mode_r == CMPC_RHALVE && flt.flyingCapDiagnostic);
      end
      CMPC_HALVE:
        clrChg = ovpAny | flt.inputOvercurrent | flt.outputShortError
               | flt.dieOvertemperature | flt.flyingCapDiagnostic
               | flt.converterOvercurrent;
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [CW-1:0] wdtCnt_r;
  logic [CW-1:0] waitCnt_r;
  logic          waiting_r;
  logic          wdtExpire;
  logic          wdtReload;
  assign wdtExpire = !watchdogTimeoutStatus_r && wdtCnt_r == CW'(WDT_CYC - 1);
  assign wdtReload = waiting_r && waitCnt_r == CW'(WAIT_CYC - 1);

  // counts from reset; host traffic restarts it and ends a timeout
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      wdtCnt_r                <= '0;
      watchdogTimeoutStatus_r <= 1'b0;
    end
    else if (hostAcc)
    begin
      wdtCnt_r                <= '0;
      watchdogTimeoutStatus_r <= 1'b0;
    end
    else if (wdtExpire)
      watchdogTimeoutStatus_r <= 1'b1;
    else if (!watchdogTimeoutStatus_r)
      wdtCnt_r <= wdtCnt_r + 1'b1;

  // sticky flag: a new expiry beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      watchdogTimeoutFlag_r <= 1'b0;
    else if (wdtExpire)
      watchdogTimeoutFlag_r <= 1'b1;
    else if (wdtFlagClr)
      watchdogTimeoutFlag_r <= 1'b0;

  // restore wait after expiry; not cancelled by host traffic
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      waiting_r <= 1'b0;
      waitCnt_r <= '0;
    end
    else if (wdtExpire)
    begin
      waiting_r <= 1'b1;
      waitCnt_r <= '0;
    end
    else if (wdtReload)
      waiting_r <= 1'b0;
    else if (waiting_r)
      waitCnt_r <= waitCnt_r + 1'b1;

  // ----------------------------------------------------------------
  // control bits: host writes, fault clears, watchdog restore
  // ----------------------------------------------------------------
  // a fault clear overrides a host write landing in the same cycle
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      cfg_r <= cmpc_cfg_s'(`CMPC_CFG_RESET);
    else if (wdtReload)
      cfg_r <= cmpc_cfg_s'(`CMPC_CFG_RESET);
    else
    begin
      if (hostWr)
        cfg_r <= cfgWrData;
      if (clrChg)
        cfg_r.chargeEnable <= 1'b0;
      if (clrRev)
        cfg_r.reverseEnable <= 1'b0;
      if (clrSw)
        cfg_r.inputSwitchControl <= 2'b00;
    end

  // ----------------------------------------------------------------
  // soft-start sequencer
  // ----------------------------------------------------------------
  cmpc_ss_e      ss_r;
  cmpc_ss_e      ssNxt;
  logic [CW-1:0] holdCnt_r;
  logic [CW-1:0] holdLoad;
  logic          lowOk;
  logic          ovpHold_r;     // hold is an overvoltage recovery
  // reverse modes need low-input set, forward modes need it clear
  assign lowOk = flt.lowInputStatus == isRev;
  assign holdLoad = stopOvp ? (cfg_r.recoveryDeglitchSelect ? CW'(RECOV1_CYC)
                                                            : CW'(RECOV0_CYC))
                  : stopShort ? (cfg_r.outErrOffTimeSel ? CW'(HICC1_CYC)
                                                        : CW'(HICC0_CYC))
                  : CW'(1);

  always_comb
  begin
    ssNxt = ss_r;
    unique case (ss_r)
      CMPC_SS_IDLE:
        if (charging)
          ssNxt = CMPC_SS_CHECK;
      CMPC_SS_CHECK:
        if (!charging)
          ssNxt = CMPC_SS_IDLE;
        else if (vinOk && lowOk)
          ssNxt = CMPC_SS_RUN;
      CMPC_SS_RUN:
        if (!charging || clrChg)
          ssNxt = CMPC_SS_IDLE;
        else if (stopOcp || stopOvp || stopShort)
          ssNxt = CMPC_SS_HOLD;
      CMPC_SS_HOLD:
        if (!charging)
          ssNxt = CMPC_SS_IDLE;
        else if (holdCnt_r == CW'(1) && !(ovpHold_r && ovpAny))
          ssNxt = CMPC_SS_CHECK;
    endcase
  end

  // recovery counter restarts while the overvoltage persists
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      ss_r       <= CMPC_SS_IDLE;
      holdCnt_r  <= '0;
      ovpHold_r  <= 1'b0;
      switchOn_r <= 1'b0;
    end
    else
    begin
      ss_r       <= ssNxt;
      switchOn_r <= ssNxt == CMPC_SS_RUN;
      if (ss_r == CMPC_SS_RUN && ssNxt == CMPC_SS_HOLD)
      begin
        holdCnt_r <= holdLoad;
        ovpHold_r <= stopOvp;
      end
      else if (ss_r == CMPC_SS_HOLD && ovpHold_r && ovpAny)
        holdCnt_r <= cfg_r.recoveryDeglitchSelect ? CW'(RECOV1_CYC) : CW'(RECOV0_CYC);
      else if (ss_r == CMPC_SS_HOLD && holdCnt_r != CW'(1))
        holdCnt_r <= holdCnt_r - 1'b1;
    end

  // ----------------------------------------------------------------
  // interrupt pulse and indicator
  // ----------------------------------------------------------------
  logic          fltRise;
  logic [CW-1:0] pulseCnt_r;
  assign fltRise = mode_r == CMPC_STANDBY
                   && (|(flt & ~fltPrev) || (wirelessSync && !wirelessPrev));

  // fixed-width low pulse; a new event re-arms the full width
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      fltPrev      <= '0;
      wirelessPrev <= 1'b0;
      pulseCnt_r   <= '0;
      intN_r       <= 1'b1;
    end
    else
    begin
      fltPrev      <= flt;
      wirelessPrev <= wirelessSync;
      if (wdtExpire || fltRise)
      begin
        pulseCnt_r <= CW'(PULSE_CYC - 1);
        intN_r     <= 1'b0;
      end
      else if (pulseCnt_r != '0)
        pulseCnt_r <= pulseCnt_r - 1'b1;
      else
        intN_r <= 1'b1;
    end

  // indicator in low power only with both enable bits
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      wirelessInputGood_r <= 1'b0;
    else
      wirelessInputGood_r <= wirelessSync && cfg_r.wirelessGoodIndicatorEn
        && (protOn || cfg_r.wirelessGoodLowpowerEn);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_expire;
    wdtExpire;
  endsequence
  sequence s_pulse;
    !intN_r [*8];
  endsequence

  a_host_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    !hostReady_r |-> $stable(cfg_r) || $past(wdtReload || clrChg || clrRev || clrSw))
    else $error("control written before release");
  a_wake_time: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(hostReady_r) |-> $past(wakeCnt_r) == CW'(WAKE_CYC - 1))
    else $error("release time wrong");
  a_wdt_runs: assert property (@(posedge ref_clk) disable iff (!nrst)
    !watchdogTimeoutStatus_r && !hostAcc && !wdtExpire |=> wdtCnt_r == $past(wdtCnt_r) + 1'b1)
    else $error("watchdog not counting");
  a_wdt_expiry: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_expire |=> watchdogTimeoutFlag_r && !intN_r)
    else $error("expiry effects missing");
  a_int_width: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_expire |=> s_pulse)
    else $error("interrupt pulse too short");
  a_wdt_access: assert property (@(posedge ref_clk) disable iff (!nrst)
    hostAcc |=> !watchdogTimeoutStatus_r && wdtCnt_r == '0)
    else $error("access did not restart watchdog");
  a_low_power: assert property (@(posedge ref_clk) disable iff (!nrst)
    !enLow |=> mode_r == CMPC_LOWPWR)
    else $error("low power not entered");
  a_lp_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == CMPC_LOWPWR |-> !clrChg && !clrSw && !fltRise)
    else $error("protection active in low power");
  a_rev_ocp: assert property (@(posedge ref_clk) disable iff (!nrst)
    clrSw && !wdtReload |=> cfg_r.inputSwitchControl == 2'b00)
    else $error("switch field not cleared");
  a_halve_clr: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode_r == CMPC_HALVE && flt.flyingCapDiagnostic |=> !cfg_r.chargeEnable)
    else $error("halving fault kept charge enable");
  a_rev_clr: assert property (@(posedge ref_clk) disable iff (!nrst)
    isRev && flt.converterOvercurrent |=> !cfg_r.chargeEnable && !cfg_r.reverseEnable)
    else $error("reverse fault kept enables");
  a_ss_block: assert property (@(posedge ref_clk) disable iff (!nrst)
    ss_r == CMPC_SS_CHECK && !lowOk |=> ss_r != CMPC_SS_RUN)
    else $error("soft-start not blocked");
endmodule

// *** cmpc_host_model.sv ***
// host processor model driving the control port of the charger controller
`timescale 1ns/1ns
module cmpc_host_model (
  // clock and release from the device
  input  wire logic                 ref_clk,
  input  wire logic                 hostReady,
  // control port toward the device
  output logic                      cfgWr,
  output cmpc_pkg::cmpc_cfg_s       cfgWrData,
  output logic                      regRead,
  output logic                      wdtFlagClr
);
  import cmpc_pkg::*;
  // idle levels from time zero
  initial
  begin
    cfgWr      = 1'b0;
    cfgWrData  = 10'h000;
    regRead    = 1'b0;
    wdtFlagClr = 1'b0;
  end
  // one-cycle write; early skips the ready wait so a refusal can be seen
  task automatic wr(input cmpc_cfg_s d, input bit early);
    if (!early)
      wait (hostReady === 1'b1);
    @(negedge ref_clk);
    cfgWr     = 1'b1;
    cfgWrData = d;
    @(negedge ref_clk);
    cfgWr     = 1'b0;
    // released data no longer shows the last value
    cfgWrData = ~d;
  endtask
  // one-cycle register read or flag clear strobe
  task automatic strobe(input bit flagClr);
    @(negedge ref_clk);
    if (flagClr)
      wdtFlagClr = 1'b1;
    else
      regRead = 1'b1;
    @(negedge ref_clk);
    wdtFlagClr = 1'b0;
    regRead    = 1'b0;
  endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the charger mode and protection controller
`timescale 1ns/1ns
module testbench;
  import cmpc_pkg::*;
  // ----------------------------------------
  // signals, shortened counts and results
  // ----------------------------------------
  localparam int PULSE = 10;        // interrupt pulse cycles
  localparam int WDT   = 200;       // watchdog period cycles
  localparam int WAIT  = 100;       // restore wait cycles
  localparam int WAKE  = 20;        // release delay cycles
  localparam int RECOV0 = 30;       // short recovery deglitch cycles
  localparam int RECOV1 = 60;       // long recovery deglitch cycles
  localparam int HICC0 = 15;        // short hiccup off cycles
  localparam int HICC1 = 40;        // long hiccup off cycles
  logic        ref_clk = 1'b0;      // 50 MHz clock
  logic        nrst;                // supply lockout reset
  logic        enPinN;              // enable pin, active low
  logic [1:0]  addrLevel;           // address pin level
  logic        inputPresent;        // input voltage sensed
  logic        wirelessInputRaw;    // wireless input sense
  cmpc_fault_s faultRaw;            // fault comparators
  logic        cfgWr, regRead, wdtFlagClr, hostReady_r, switchOn_r, intN_r;
  logic        watchdogTimeoutStatus_r, watchdogTimeoutFlag_r, wirelessInputGood_r;
  cmpc_cfg_s   cfgWrData, cfg_r;    // control bits out and back
  cmpc_mode_e  mode_r;              // decoded mode
  logic [6:0]  slaveAddr_r;         // latched address
  logic [31:0] seed = 32'h00006BB3; // xorshift state
  int          miscompares = 0;
  int          compares = 0;
  int          dly, wid, k;
  always #10 ref_clk = ~ref_clk;
  // counts shortened so the run stays brief
  cmpc_ctrl #(.WAKE_CYC(WAKE), .PULSE_CYC(PULSE), .WDT_CYC(WDT), .WAIT_CYC(WAIT),
    .RECOV0_CYC(RECOV0), .RECOV1_CYC(RECOV1), .HICC0_CYC(HICC0), .HICC1_CYC(HICC1))
    cmpc_ctrl_inst (
    .ref_clk, .nrst, .enPinN, .addrLevel, .inputPresent, .wirelessInputRaw, .faultRaw,
    .cfgWr, .cfgWrData, .regRead, .wdtFlagClr, .hostReady_r, .slaveAddr_r, .cfg_r,
    .mode_r, .switchOn_r, .watchdogTimeoutStatus_r, .watchdogTimeoutFlag_r, .intN_r,
    .wirelessInputGood_r);
  cmpc_host_model host_inst (.ref_clk, .hostReady(hostReady_r), .cfgWr, .cfgWrData,
    .regRead, .wdtFlagClr);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // expected mode from pin and bits
  function automatic cmpc_mode_e expMode(input logic en, ce, topo, rev);
    if (en)
      return CMPC_LOWPWR;
    if (!ce)
      return CMPC_STANDBY;
    return cmpc_mode_e'(6'h04 << {topo, rev});
  endfunction
  // expected {chargeEnable, reverseEnable, switch field} after fault bit f
  function automatic logic [3:0] expFault(input logic en, topo, rev, ar, input int f);
    logic clrCe;
    clrCe = 1'b0;
    if (en)
      return {1'b1, rev, 2'b10};
    if (f == 5)
      return {1'b1, rev, 2'b00};
    case (f)
      8, 7: clrCe = !(!topo && !rev && ar);
      6, 3, 1: clrCe = !(!topo && !rev && f != 3);
      4: clrCe = topo && !rev;
      default: clrCe = topo;
    endcase
    return {!clrCe, rev && !(rev && (f == 6 || f == 3 || f == 1)), 2'b10};
  endfunction
  // cycles until the interrupt falls, then cycles it stays low
  task automatic waitLow(output int d, output int w);
    d = 0;
    w = 0;
    while (intN_r !== 1'b0 && d < 400)
    begin
      @(negedge ref_clk);
      d++;
    end
    while (intN_r === 1'b0 && w < 400)
    begin
      @(negedge ref_clk);
      w++;
    end
  endtask
  // one mode and one fault, random side bits
  task automatic trial(input logic [1:0] m, input int f);
    logic en, lowOk, vin;
    logic [3:0] e;
    cmpc_cfg_s c;
    en = (rnd() % 8) == 0;
    lowOk = (rnd() % 6) != 0;
    vin = (rnd() % 6) != 0;
    c = {1'b1, m[0], m[1], 2'b10, 1'(rnd() % 2), 1'(rnd() % 2), 2'b00, 1'(rnd() % 2)};
    @(negedge ref_clk);
    enPinN = en;
    inputPresent = vin;
    faultRaw = 9'h000;
    faultRaw.lowInputStatus = lowOk ? m[0] : !m[0];
    // standby first, so a converter left running by the last trial stops
    host_inst.wr(c & 10'h1FF, 1'b0);
    host_inst.wr(c, 1'b0);
    repeat (10) @(negedge ref_clk);
    chk("mode", {4'h0, expMode(en, 1'b1, m[1], m[0])}, {4'h0, mode_r});
    chk("switch", {9'h000, lowOk && vin && !en}, {9'h000, switchOn_r});
    inputPresent = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("vinStart", {9'h000, lowOk && !en}, {9'h000, switchOn_r});
    if (!lowOk)
      return;
    faultRaw[f] = 1'b1;
    repeat (8) @(negedge ref_clk);
    e = expFault(en, m[1], m[0], c.autoRecoveryEnable, f);
    chk("enables", {8'h00, e[3:2]}, {8'h00, cfg_r[9:8]});
    chk("switchField", {8'h00, e[1:0]}, {8'h00, cfg_r.inputSwitchControl});
    faultRaw[f] = 1'b0;
    repeat (8) @(negedge ref_clk);
    k = e[3] && !en && !(m == 2'b00 && (f == 8 || f == 7 || f == 4));
    chk("restart", 10'(k), {9'h000, switchOn_r});
    repeat (70) @(negedge ref_clk);
    chk("recover", {9'h000, e[3] && !en}, {9'h000, switchOn_r});
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    enPinN = 1'b1;
    addrLevel = 2'(rnd() % 4);
    inputPresent = 1'b1;
    wirelessInputRaw = 1'b0;
    faultRaw = 9'h000;
    repeat (5) @(negedge ref_clk);
    chk("cfgReset", 10'h010, cfg_r);
    nrst = 1'b1;
    host_inst.wr(10'h3FF, 1'b1);
    repeat (16) @(negedge ref_clk);
    chk("earlyReady", 10'h000, {9'h000, hostReady_r});
    chk("earlyWrite", 10'h010, cfg_r);
    repeat (4) @(negedge ref_clk);
    chk("ready", 10'h001, {9'h000, hostReady_r});
    chk("address", {3'h0, 7'h50 + 7'(addrLevel)}, {3'h0, slaveAddr_r});
    $display("test powerup done");
    enPinN = 1'b0;
    host_inst.wr(10'h040, 1'b0);
    repeat (10) @(negedge ref_clk);
    chk("standby", {4'h0, CMPC_STANDBY}, {4'h0, mode_r});
    faultRaw.dieOvertemperature = 1'b1;
    waitLow(dly, wid);
    chk("standbyIrq", 10'(PULSE), 10'(dly < 8 ? wid : 0));
    $display("test standby done");
    for (int i = 0; i < 32; i++)
      trial(2'(i / 8), i % 8 + 1);
    $display("test protections done");
    // second reset in mid-run with another address level
    @(negedge ref_clk);
    nrst = 1'b0;
    enPinN = 1'b1;
    faultRaw = 9'h000;
    wirelessInputRaw = 1'b1;
    addrLevel = ~addrLevel;
    @(negedge ref_clk);
    chk("cfgReset", 10'h010, cfg_r);
    nrst = 1'b1;
    repeat (WAKE - 2) @(negedge ref_clk);
    chk("earlyReady", 10'h000, {9'h000, hostReady_r});
    repeat (4) @(negedge ref_clk);
    chk("ready", 10'h001, {9'h000, hostReady_r});
    chk("address", {3'h0, 7'h50 + 7'(addrLevel)}, {3'h0, slaveAddr_r});
    $display("test midreset done");
    for (int i = 0; i < 4; i++)
    begin
      host_inst.wr(10'h040 | 10'(i << 1), 1'b0);
      repeat (6) @(negedge ref_clk);
      chk("indicator", 10'(i == 3), {9'h000, wirelessInputGood_r});
    end
    waitLow(dly, wid);
    chk("wdtTime", 10'h001, 10'(dly >= WDT - 10 && dly <= WDT));
    chk("wdtPulse", 10'(PULSE), 10'(wid));
    chk("wdtBits", 10'h003, {8'h00, watchdogTimeoutStatus_r, watchdogTimeoutFlag_r});
    for (k = 0; cfg_r !== 10'h010 && k < 200; k++)
      @(negedge ref_clk);
    chk("restore", 10'h001, 10'(wid + k >= WAIT - 4 && wid + k <= WAIT + 4));
    host_inst.strobe(1'b0);
    repeat (4) @(negedge ref_clk);
    chk("wdtAccess", 10'h001, {8'h00, watchdogTimeoutStatus_r, watchdogTimeoutFlag_r});
    host_inst.strobe(1'b1);
    repeat (4) @(negedge ref_clk);
    chk("flagClear", 10'h000, {9'h000, watchdogTimeoutFlag_r});
    $display("test watchdog done");
    conclude();
  end
  initial
  begin
    #(20 * 20000);
    miscompares++;
    $display("ERROR run expected end seen timeout");
    conclude();
  end
endmodule
